// >>> i2crp_top.sv
// Two-wire slave port giving a bus master access to a register array.
// Assumes rst is synchronous to clk_sys; bus pins are asynchronous.
// What this block does
// - Serve the bus only while enable pin low
// - Own address is one of two values
// - Select low 1011001, select high 0001110
// - Work at 100 and 400 kbit/s
// - Clock input only; drive data when needed
// - Start and stop are data edges, clock high
// - Transfers bracketed by start, stop; repeats allowed
// - Eight-bit units, ack on ninth pulse
// - Match address and ack; else ignore transfer
// - First written byte loads the pointer
// - Pointer increments after each written byte that follows it
// - Repeated start takes new address, pointer
// - Stop ends participation; wait for start
// - Read returns pointed register, then increments
// - Pointer loads only by a write
`timescale 1ns/1ns
module i2crp_top
#(
  parameter int NUM_REGS = 256 // Depth of the register array
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Device pins
  input wire logic serial_port_enable_n,
  input wire logic bus_address_select,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Status toward the device core
  output logic wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  // ********************
  // Types and storage
  // ********************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, // Waiting for start
    ST_ADDR = 5'h02, // Shifting address byte
    ST_RECV = 5'h04, // Shifting a written byte
    ST_SEND = 5'h08, // Shifting a read byte out
    ST_IGNR = 5'h10  // Not addressed or read nacked, wait for stop or start
  } i2crp_state_t;
  i2crp_state_t state_r; // Protocol state
  logic [7:0] regs [NUM_REGS]; // Register array
  logic [7:0] ptr_r; // Register base pointer
  logic [7:0] shift_r; // Shift register
  logic [3:0] bit_r; // Bit count within unit, 8 means ack slot
  logic ptr_loaded_r; // Pointer byte already taken in this write
  logic ack_slot_r; // Ack pulse follows
  logic send_ack_r; // Drive ack low in ninth pulse
  logic scl_s, sda_s, en_n_s, sel_s; // Synchronised pins
  logic scl_d_r, sda_d_r; // Previous synchronised levels
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [6:0] own_addr;
  // Pointer advance, used on write and read
  function automatic logic [7:0] i2crp_inc(input logic [7:0] p);
    i2crp_inc = p + 8'h01;
  endfunction : i2crp_inc
  // ********************
  // Pin synchronisers
  // ********************
  i2crp_sync #(.RESET_VAL(1'b1)) u_scl (.clk_sys(clk_sys), .rst(rst), .ce(ce), .d_async(scl_i), .q_sync(scl_s));
  i2crp_sync #(.RESET_VAL(1'b1)) u_sda (.clk_sys(clk_sys), .rst(rst), .ce(ce), .d_async(sda_i), .q_sync(sda_s));
  i2crp_sync #(.RESET_VAL(1'b1)) u_en (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .d_async(serial_port_enable_n), .q_sync(en_n_s));
  i2crp_sync #(.RESET_VAL(1'b1)) u_sel (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .d_async(bus_address_select), .q_sync(sel_s));
  // ********************
  // Edge and condition detect
  // ********************
  // Previous levels for edge finding
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else if (ce)
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  // Sampling every system clock covers far more than fast rate needs
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign own_addr = sel_s ? i2crp_pkg::ADDR_SEL_HIGH : i2crp_pkg::ADDR_SEL_LOW;
  // ********************
  // Protocol engine
  // ********************
  // Shifts bits, counts units, handles ack slots and the pointer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      ptr_r <= i2crp_pkg::PTR_RESET;
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      ptr_loaded_r <= 1'b0;
      ack_slot_r <= 1'b0;
      send_ack_r <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else if (ce)
    begin
      wr_strobe <= 1'b0;
      if (en_n_s)
      begin
        // Port disabled: stand-alone, bus ignored
        state_r <= ST_IDLE;
        send_ack_r <= 1'b0;
      end
      else if (start_det)
      begin
        // Start or repeated start opens a new address phase
        state_r <= ST_ADDR;
        bit_r <= 4'h0;
        ptr_loaded_r <= 1'b0;
        send_ack_r <= 1'b0;
        ack_slot_r <= 1'b0;
      end
      else if (stop_det)
      begin
        state_r <= ST_IDLE;
        send_ack_r <= 1'b0;
      end
      else if (state_r != ST_IDLE && state_r != ST_IGNR)
      begin
        if (scl_rise && !ack_slot_r && state_r != ST_SEND)
        begin
          // Receive one bit, msb first, on the rising edge
          shift_r <= {shift_r[6:0], sda_s};
          bit_r <= bit_r + 4'h1;
        end
        else if (scl_rise && ack_slot_r && state_r == ST_SEND && !send_ack_r)
        begin
          // Master answer on the ninth pulse of a read unit; the address ack slot is ours
          if (sda_s)
            state_r <= ST_IGNR;
        end
        else if (scl_fall && ack_slot_r)
        begin
          // End of ninth pulse: release ack, load next read byte
          ack_slot_r <= 1'b0;
          send_ack_r <= 1'b0;
          bit_r <= 4'h0;
          if (state_r == ST_SEND)
          begin
            shift_r <= regs[ptr_r];
            ptr_r <= i2crp_inc(ptr_r);
          end
        end
        else if (scl_fall && state_r == ST_SEND)
        begin
          // Next bit out after each falling edge
          shift_r <= {shift_r[6:0], 1'b1};
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'(i2crp_pkg::BITS_PER_UNIT - 1))
            ack_slot_r <= 1'b1;
        end
        else if (scl_fall && bit_r == 4'(i2crp_pkg::BITS_PER_UNIT))
        begin
          // Eight bits received: decide the ack for the ninth pulse
          ack_slot_r <= 1'b1;
          if (state_r == ST_ADDR)
          begin
            if (shift_r[7:1] == own_addr)
            begin
              send_ack_r <= 1'b1;
              // Read: the first byte loads as the address ack pulse ends
              if (shift_r[0])
                state_r <= ST_SEND;
              else
                state_r <= ST_RECV;
            end
            else
            begin
              state_r <= ST_IGNR;
              ack_slot_r <= 1'b0;
            end
          end
          else
          begin
            send_ack_r <= 1'b1;
            if (!ptr_loaded_r)
            begin
              ptr_r <= shift_r;
              ptr_loaded_r <= 1'b1;
            end
            else
            begin
              wr_strobe <= 1'b1;
              wr_addr <= ptr_r;
              wr_data <= shift_r;
              ptr_r <= i2crp_inc(ptr_r);
            end
          end
        end
      end
    end
  end
  // ********************
  // Register array
  // ********************
  // Written bytes stored at the pointer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs[i] <= i2crp_pkg::DATA_RESET;
    end
    else if (ce && !en_n_s && !start_det && !stop_det && state_r == ST_RECV && scl_fall && !ack_slot_r &&
             bit_r == 4'(i2crp_pkg::BITS_PER_UNIT) && ptr_loaded_r)
      regs[ptr_r] <= shift_r;
  end
  // ********************
  // Data line drive
  // ********************
  // Drives only ack low or zero read bits; pin output stays low
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (ce)
    begin
      sda_o <= 1'b0;
      if (en_n_s || start_det || stop_det || state_r == ST_IDLE || state_r == ST_IGNR)
        sda_oe <= 1'b0;
      else if (ack_slot_r)
        // Our ack, address ack of a read included; master's slot leaves it clear
        sda_oe <= send_ack_r;
      else if (state_r == ST_SEND)
        sda_oe <= ~shift_r[7];
      else
        sda_oe <= 1'b0;
    end
  end
endmodule : i2crp_top

// >>> i2crp_pkg.sv
// Constants shared by the two-wire register port.
// Assumes one system clock; the bus pins arrive asynchronously.
package i2crp_pkg;
  // ********************
  // Bus addresses
  // ********************
  localparam logic [6:0] ADDR_SEL_LOW = 7'h59;  // 1011001 when select is low
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h0e; // 0001110 when select is high
  // ********************
  // Framing and timing
  // ********************
  localparam int BITS_PER_UNIT = 8;       // Bits in one transferred unit
  localparam int CLK_SYS_HZ = 50000000;   // System clock rate
  localparam int FAST_RATE_BPS = 400000;  // Highest bus bit rate
  // System clocks per bus bit at fast rate
  localparam int CYC_PER_BIT = CLK_SYS_HZ / FAST_RATE_BPS;
  localparam logic [7:0] PTR_RESET = 8'h00; // Pointer value after reset
  localparam logic [7:0] DATA_RESET = 8'h00; // Register value after reset
endpackage : i2crp_pkg

// >>> i2crp_sync.sv
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the destination clock runs much faster than the source edges.
`timescale 1ns/1ns
module i2crp_sync
#(
  parameter logic RESET_VAL = 1'b1
)
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Async in, synced out
  input wire logic d_async,
  output logic q_sync
);
  logic meta_r; // First stage, read only by the second
  // ********************
  // Two stage capture
  // ********************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_r <= RESET_VAL;
      q_sync <= RESET_VAL;
    end
    else if (ce)
    begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule : i2crp_sync

// >>> i2crp_props.sv
// Assertions on the pins of the two-wire register port.
// Assumes binding into every i2crp_top; one clock domain.
`timescale 1ns/1ns
module i2crp_props
#(
  parameter int NUM_REGS = 256
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus pins
  input wire logic serial_port_enable_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Write status
  input wire logic wr_strobe,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Stop seen on the pins
  sequence s_stop; scl_i && $rose(sda_i); endsequence
  property p_rst; disable iff (1'b0) rst |=> !sda_oe && !wr_strobe; endproperty
  a_rst: assert property (p_rst) else $error("driving in reset");
  property p_drv; !sda_o; endproperty
  a_drv: assert property (p_drv) else $error("data driven high");
  property p_dis; serial_port_enable_n [*8] |-> !sda_oe && !wr_strobe; endproperty
  a_dis: assert property (p_dis) else $error("active while off");
  property p_pls; wr_strobe |=> !wr_strobe; endproperty
  a_pls: assert property (p_pls) else $error("strobe too long");
  property p_oe; $changed(sda_oe) |-> !scl_i; endproperty
  a_oe: assert property (p_oe) else $error("data moved, clock high");
  property p_stb; wr_strobe |-> !scl_i; endproperty
  a_stb: assert property (p_stb) else $error("strobe off slot");
  property p_hold; !wr_strobe |-> $stable(wr_addr) && $stable(wr_data); endproperty
  a_hold: assert property (p_hold) else $error("write status moved");
  property p_stop; s_stop |=> !wr_strobe [*8]; endproperty
  a_stop: assert property (p_stop) else $error("write after stop");
endmodule : i2crp_props
bind i2crp_top i2crp_props #(.NUM_REGS(NUM_REGS)) u_props (.clk_sys(clk_sys), .rst(rst),
  .serial_port_enable_n(serial_port_enable_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));

// >>> i2crp_master.sv
// Behavioural bus master facing the register port.
// Assumes SDA has a pull-up; the slave pulls low with sda_oe.
`timescale 1ns/1ns
module i2crp_master
(
  // Clock and slave drive
  input wire logic clk_sys,
  input wire logic sda_oe,
  // Bus lines
  output logic scl,
  output wire logic sda
);
  logic pull; // Master pulls data low
  // Wired-and of both pull-downs, idle high
  assign sda = !(sda_oe || pull);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Wait n system clocks
  task automatic h(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : h
  // One bit in a 160 ns clock period: low 5 clocks, high 3
  // Data moves 3 clocks after the fall; the slave moves 4 after it,
  // both still ahead of the next rise
  task automatic bit_x(input logic b, output logic r);
    pull <= !b;
    h(2);
    scl <= 1'b1;
    h(2);
    r = sda;
    h(1);
    scl <= 1'b0;
    h(3);
  endtask : bit_x
  // Start or repeated start
  task automatic start_c;
    pull <= 1'b0;
    h(4);
    scl <= 1'b1;
    h(8);
    pull <= 1'b1;
    h(8);
    scl <= 1'b0;
    h(4);
  endtask : start_c
  // Stop, bus left idle
  task automatic stop_c;
    pull <= 1'b1;
    h(4);
    scl <= 1'b1;
    h(8);
    pull <= 1'b0;
    h(8);
  endtask : stop_c
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(a, ak);
  endtask : xfer
endmodule : i2crp_master

// >>> tb_i2crp_top.sv
// Self-checking bench for the two-wire register port.
// Assumes i2crp_master plays the bus master on clk_sys.
`timescale 1ns/1ns
module tb_i2crp_top;
  typedef struct {logic sel; logic [6:0] a; logic [7:0] p, d; logic hit;} i2crp_row_t;
  logic clk_sys, rst, ce, en_n, sel, scl, sda_o, sda_oe, wr_strobe, ak;
  wire sda;
  logic [7:0] wr_addr, wr_data, q, la, ld;
  int n_fail, tests_run, n_wr, n0;
  // Select level, address, pointer, data, hit
  i2crp_row_t rows [4] = '{'{1'b0, i2crp_pkg::ADDR_SEL_LOW, 8'h10, 8'ha5, 1'b1},
    '{1'b1, i2crp_pkg::ADDR_SEL_HIGH, 8'hff, 8'h3c, 1'b1}, '{1'b0, i2crp_pkg::ADDR_SEL_HIGH, 8'h20, 8'h11, 1'b0},
    '{1'b1, i2crp_pkg::ADDR_SEL_LOW, 8'h21, 8'h22, 1'b0}};
  i2crp_top uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .serial_port_enable_n(en_n),
    .bus_address_select(sel), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
  i2crp_master m (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // Clock at 50 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Count and capture write strobes
  always @(posedge clk_sys)
    if (wr_strobe === 1'b1)
    begin
      n_wr++;
      la = wr_addr;
      ld = wr_data;
    end
  // Compare and report
  task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask : check
  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Write transfer: address, pointer, data bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$], input logic ea);
    m.start_c();
    m.xfer({a, 1'b0}, 1'b1, q, ak);
    check("addr ack", ak, ea);
    m.xfer(p, 1'b1, q, ak);
    check("ptr ack", ak, ea);
    foreach (d[i])
    begin
      m.xfer(d[i], 1'b1, q, ak);
      check("data ack", ak, ea);
    end
    m.stop_c();
  endtask : wr
  // Read transfer, optionally after pointer write and repeated start
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input bit sp, input logic [7:0] e[$]);
    m.start_c();
    if (sp)
    begin
      m.xfer({a, 1'b0}, 1'b1, q, ak);
      m.xfer(p, 1'b1, q, ak);
      m.start_c();
    end
    m.xfer({a, 1'b1}, 1'b1, q, ak);
    check("rd ack", ak, 1'b0);
    foreach (e[i])
    begin
      m.xfer(8'hff, i == e.size() - 1, q, ak);
      check("rd data", q, e[i]);
    end
    m.h(4);
    check("nack release", sda_oe, 1'b0);
    m.stop_c();
  endtask : rd
  // Hang guard: the tests need about 4100 clocks, allow 20000
  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    en_n = 1'b0;
    sel = 1'b0;
    m.h(6);
    rst <= 1'b0;
    m.h(4);
    check("oe", sda_oe, 1'b0);
    check("wr_addr", wr_addr, 8'h00);
    $display("reset test done");
    foreach (rows[i])
    begin
      sel <= rows[i].sel;
      m.h(8);
      n0 = n_wr;
      wr(rows[i].a, rows[i].p, '{rows[i].d}, !rows[i].hit);
      check("strobes", 8'(n_wr - n0), 8'(rows[i].hit));
      if (rows[i].hit)
      begin
        check("wr_addr", la, rows[i].p);
        check("wr_data", ld, rows[i].d);
        rd(rows[i].a, rows[i].p, 1'b1, '{rows[i].d});
      end
      $display("row %0d done", i);
    end
    sel <= 1'b0;
    m.h(8);
    wr(i2crp_pkg::ADDR_SEL_LOW, 8'hfe, '{8'h01, 8'h02, 8'h03}, 1'b0);
    check("wrap addr", la, 8'h00);
    rd(i2crp_pkg::ADDR_SEL_LOW, 8'hfe, 1'b1, '{8'h01, 8'h02, 8'h03});
    wr(i2crp_pkg::ADDR_SEL_LOW, 8'hff, '{}, 1'b0);
    rd(i2crp_pkg::ADDR_SEL_LOW, 8'h00, 1'b0, '{8'h02, 8'h03});
    $display("burst test done");
    en_n <= 1'b1;
    m.h(8);
    n0 = n_wr;
    wr(i2crp_pkg::ADDR_SEL_LOW, 8'h40, '{8'h77}, 1'b1);
    check("off strobes", 8'(n_wr - n0), 8'h00);
    en_n <= 1'b0;
    $display("disable test done");
    // Clock enable low freezes the port: no ack, nothing stored
    m.h(8);
    ce <= 1'b0;
    n0 = n_wr;
    wr(i2crp_pkg::ADDR_SEL_LOW, 8'h50, '{8'h99}, 1'b1);
    check("frozen strobes", 8'(n_wr - n0), 8'h00);
    ce <= 1'b1;
    m.h(8);
    rd(i2crp_pkg::ADDR_SEL_LOW, 8'h50, 1'b1, '{8'h00});
    $display("clock enable test done");
    finish_test();
  end
endmodule : tb_i2crp_top
